// ---- hw/dmtc_pkg.sv ----
// Functional notes
// - Control register is 32 bits; power-on reset clears it; manual reset and standby keep it.
// - Bit 30 picks all-bank precharge or mode register setting for SDRAM setup.
// - Bits 29..27 give post-refresh precharge of 0 to 21 cycles, step 3.
// - Reserved bits 26..24, 22, 18 read zero; software writes zero there.
// - Bit 23 gives DRAM column strobe negation of 1 or 2 cycles.
// - DRAM precharge field bits 21..19 gives 0 to 7 cycles before row reassert.
// - SDRAM precharge gives 1 to 8 cycles; 4 or more barred in row-hold mode.
// - DRAM delay bits 17..16 give row-to-column delay of 2 to 5 cycles.
// - SDRAM delay codes 1..3 give 2 to 4 cycles; 0 barred; 4 barred in row-hold.
// - SDRAM auto-precharge write waits precharge plus write delay before next activate.
// - SDRAM row-hold write waits the write delay before the next precharge.
// - Write delay bits 15..13, SDRAM only, codes 0..4 give 1 to 5; 5..7 reserved.
package dmtc_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned CNT_W = 5;
    typedef logic [CNT_W-1:0] dmtc_cnt_t;
    localparam logic [ADDR_W-1:0] MTC_OFFSET = 12'h000;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
    localparam logic [31:0] MTC_RESET = 32'h00000000;
    localparam logic [31:0] MTC_WMASK = 32'hF8BBFFFF;
    localparam int unsigned ROW_HOLD_BIT = 31;
    localparam int unsigned SETUP_CMD_BIT = 30;
    localparam int unsigned POST_REFRESH_LSB = 27;
    localparam int unsigned COL_NEGATE_BIT = 23;
    localparam int unsigned ROW_PRECHARGE_LSB = 19;
    localparam int unsigned ROW_TO_COL_LSB = 16;
    localparam int unsigned WRITE_PRECHARGE_LSB = 13;
    localparam int unsigned STAT_ACT_BIT = 0;
    localparam int unsigned STAT_COL_BIT = 1;
    localparam int unsigned STAT_PRE_BIT = 2;
    localparam int unsigned STAT_CFG_BIT = 3;
    localparam dmtc_cnt_t POST_REFRESH_STEP = 5'h03;
    localparam dmtc_cnt_t DRAM_RCD_BASE = 5'h02;
    localparam dmtc_cnt_t ONE_CYCLE = 5'h01;
    localparam logic [2:0] SDRAM_TPC_HOLD_LIMIT = 3'h3;
    localparam logic [1:0] SDRAM_RCD_HOLD_LIMIT = 2'h3;
    localparam logic [2:0] WRITE_PRECHARGE_DELAY_MAX_CODE = 3'h4;

    function automatic dmtc_cnt_t post_refresh_cycles(input logic [2:0] code);
        post_refresh_cycles = 5'(code * POST_REFRESH_STEP);
    endfunction

    function automatic dmtc_cnt_t row_precharge_cycles(input logic [2:0] code,
                                                       input logic sdram);
        row_precharge_cycles = sdram ? 5'({2'h0, code} + ONE_CYCLE) : 5'({2'h0, code});
    endfunction

    function automatic dmtc_cnt_t row_to_col_cycles(input logic [1:0] code, input logic sdram);
        row_to_col_cycles = sdram ? 5'({3'h0, code} + ONE_CYCLE)
                                  : 5'({3'h0, code} + DRAM_RCD_BASE);
    endfunction

    function automatic dmtc_cnt_t write_precharge_cycles(input logic [2:0] code);
        logic [2:0] c;
        c = (code > WRITE_PRECHARGE_DELAY_MAX_CODE) ? WRITE_PRECHARGE_DELAY_MAX_CODE : code;
        write_precharge_cycles = 5'({2'h0, c} + ONE_CYCLE);
    endfunction

    function automatic dmtc_cnt_t max_cnt(input dmtc_cnt_t a, input dmtc_cnt_t b);
        max_cnt = (a > b) ? a : b;
    endfunction
endpackage

// ---- hw/dmtc_gap_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface dmtc_gap_if;
    logic load;
    dmtc_pkg::dmtc_cnt_t len;
    logic busy;
    modport timer (input load, input len, output busy);
    modport user (output load, output len, input busy);
endinterface
`default_nettype wire

// ---- hw/dmtc_gap_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module dmtc_gap_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic flush,
    dmtc_gap_if.timer gap
);
    dmtc_pkg::dmtc_cnt_t count_q;
    dmtc_pkg::dmtc_cnt_t count_d;
    logic busy_q;
    logic busy_d;

    // Longest pending wait wins when a new one arrives
    always_comb begin
        count_d = (count_q != 5'h00) ? 5'(count_q - 5'h01) : 5'h00;
        if (gap.load) begin
            count_d = dmtc_pkg::max_cnt(count_d, gap.len);
        end
        if (flush) begin
            count_d = 5'h00;
        end
        busy_d = (count_d != 5'h00);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 5'h00;
            busy_q <= 1'b0;
        end else if (pce) begin
            count_q <= count_d;
            busy_q <= busy_d;
        end
    end

    assign gap.busy = busy_q;
endmodule // dmtc_gap_timer
`default_nettype wire

// ---- hw/dmtc_top.sv ----
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dmtc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dmtc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic manual_reset,
    input wire logic sdram_sel,
    input wire logic refresh_end,
    input wire logic row_negate,
    input wire logic precharge_issued,
    input wire logic bank_active,
    input wire logic col_negate,
    input wire logic write_end,
    output logic row_strobe_hold_mode,
    output logic sdram_setup_command_select,
    output logic activate_blocked,
    output logic col_blocked,
    output logic precharge_blocked,
    output logic config_error
);
    logic [31:0] mtc_q;
    logic [31:0] mtc_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic cfg_err_q;
    logic cfg_err_d;
    logic flush_q;
    logic access;
    logic hit_mtc;
    logic hit_status;
    logic [2:0] post_refresh_code;
    logic [2:0] row_precharge_code;
    logic [1:0] row_to_col_code;
    logic [2:0] write_precharge_code;
    logic row_hold;
    logic sd_auto_write;
    logic sd_hold_write;
    logic [31:0] status_word;

    dmtc_gap_if act_gap ();
    dmtc_gap_if col_gap ();
    dmtc_gap_if pre_gap ();

    assign post_refresh_code = mtc_q[dmtc_pkg::POST_REFRESH_LSB +: 3];
    assign row_precharge_code = mtc_q[dmtc_pkg::ROW_PRECHARGE_LSB +: 3];
    assign row_to_col_code = mtc_q[dmtc_pkg::ROW_TO_COL_LSB +: 2];
    assign write_precharge_code = mtc_q[dmtc_pkg::WRITE_PRECHARGE_LSB +: 3];
    assign row_hold = mtc_q[dmtc_pkg::ROW_HOLD_BIT];

    // Bus access phase completes two cycles after penable rises, with pready high in the second
    assign access = psel && penable && !pready_q;
    assign hit_mtc = (paddr == dmtc_pkg::MTC_OFFSET);
    assign hit_status = (paddr == dmtc_pkg::STATUS_OFFSET);

    always_comb begin
        status_word = 32'h00000000;
        status_word[dmtc_pkg::STAT_ACT_BIT] = act_gap.busy;
        status_word[dmtc_pkg::STAT_COL_BIT] = col_gap.busy;
        status_word[dmtc_pkg::STAT_PRE_BIT] = pre_gap.busy;
        status_word[dmtc_pkg::STAT_CFG_BIT] = cfg_err_q;
    end

    always_comb begin
        mtc_d = mtc_q;
        prdata_d = prdata_q;
        pready_d = access;
        pslverr_d = 1'b0;
        // Write lands at the edge that sees pready high
        if (psel && penable && pready_q && pwrite && hit_mtc) begin
            mtc_d = pwdata & dmtc_pkg::MTC_WMASK;
        end
        if (access) begin
            prdata_d = 32'h00000000;
            if (hit_mtc) begin
                if (!pwrite) begin
                    prdata_d = mtc_q;
                end
            end else if (hit_status) begin
                if (!pwrite) begin
                    prdata_d = status_word;
                end
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // Power-on reset only; manual reset and standby never touch it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mtc_q <= dmtc_pkg::MTC_RESET;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (pce) begin
            mtc_q <= mtc_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // SDRAM settings barred always, or only while the row is held open
    always_comb begin
        cfg_err_d = 1'b0;
        if (sdram_sel) begin
            if (row_to_col_code == 2'h0) begin
                cfg_err_d = 1'b1;
            end
            if (write_precharge_code > dmtc_pkg::WRITE_PRECHARGE_DELAY_MAX_CODE) begin
                cfg_err_d = 1'b1;
            end
            if (row_hold && row_precharge_code >= dmtc_pkg::SDRAM_TPC_HOLD_LIMIT) begin
                cfg_err_d = 1'b1;
            end
            if (row_hold && row_to_col_code == dmtc_pkg::SDRAM_RCD_HOLD_LIMIT) begin
                cfg_err_d = 1'b1;
            end
        end
    end

    assign sd_auto_write = sdram_sel && !row_hold && write_end;
    assign sd_hold_write = sdram_sel && row_hold && write_end;

    // Activate gate: refresh recovery, row precharge, write recovery
    always_comb begin
        act_gap.load = refresh_end || (row_negate && !sdram_sel)
                       || (precharge_issued && sdram_sel) || sd_auto_write;
        act_gap.len = 5'h00;
        if (refresh_end) begin
            act_gap.len = dmtc_pkg::post_refresh_cycles(post_refresh_code);
        end
        if (row_negate && !sdram_sel) begin
            act_gap.len = dmtc_pkg::max_cnt(act_gap.len,
                dmtc_pkg::row_precharge_cycles(row_precharge_code, 1'b0));
        end
        if (precharge_issued && sdram_sel) begin
            act_gap.len = dmtc_pkg::max_cnt(act_gap.len,
                dmtc_pkg::row_precharge_cycles(row_precharge_code, 1'b1));
        end
        if (sd_auto_write) begin
            act_gap.len = dmtc_pkg::max_cnt(act_gap.len,
                5'(dmtc_pkg::row_precharge_cycles(row_precharge_code, 1'b1)
                + dmtc_pkg::write_precharge_cycles(write_precharge_code)));
        end
    end

    // Column gate: row-to-column delay and DRAM column negation
    always_comb begin
        col_gap.load = bank_active || (col_negate && !sdram_sel);
        col_gap.len = 5'h00;
        if (bank_active) begin
            col_gap.len = dmtc_pkg::row_to_col_cycles(row_to_col_code, sdram_sel);
        end
        if (col_negate && !sdram_sel) begin
            col_gap.len = dmtc_pkg::max_cnt(col_gap.len,
                mtc_q[dmtc_pkg::COL_NEGATE_BIT] ? 5'h02 : 5'h01);
        end
    end

    // Precharge gate: write recovery while the row is held
    always_comb begin
        pre_gap.load = sd_hold_write;
        pre_gap.len = dmtc_pkg::write_precharge_cycles(write_precharge_code);
    end

    // Manual reset clears pending waits but keeps the register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flush_q <= 1'b0;
            cfg_err_q <= 1'b0;
        end else if (pce) begin
            flush_q <= manual_reset;
            cfg_err_q <= cfg_err_d;
        end
    end

    dmtc_gap_timer u_act_timer (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .flush(flush_q),
        .gap(act_gap)
    );

    dmtc_gap_timer u_col_timer (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .flush(flush_q),
        .gap(col_gap)
    );

    dmtc_gap_timer u_pre_timer (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .flush(flush_q),
        .gap(pre_gap)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign row_strobe_hold_mode = mtc_q[dmtc_pkg::ROW_HOLD_BIT];
    assign sdram_setup_command_select = mtc_q[dmtc_pkg::SETUP_CMD_BIT];
    assign activate_blocked = act_gap.busy;
    assign col_blocked = col_gap.busy;
    assign precharge_blocked = pre_gap.busy;
    assign config_error = cfg_err_q;
endmodule // dmtc_top
`default_nettype wire

// ---- dv/dmtc_top_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module dmtc_top_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dmtc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic manual_reset,
    input wire logic sdram_sel,
    input wire logic refresh_end,
    input wire logic row_negate,
    input wire logic precharge_issued,
    input wire logic bank_active,
    input wire logic col_negate,
    input wire logic write_end,
    input wire logic row_strobe_hold_mode,
    input wire logic activate_blocked,
    input wire logic col_blocked,
    input wire logic config_error
);
    logic [31:0] shadow_q;
    logic [31:0] shadow_d;
    logic wr_hit;
    assign wr_hit = pce && psel && penable && pready && pwrite && paddr == dmtc_pkg::MTC_OFFSET;
    always_comb shadow_d = wr_hit ? pwdata : shadow_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) shadow_q <= 32'h00000000;
        else shadow_q <= shadow_d;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence quiet_s;
        !bank_active && !col_negate && !manual_reset;
    endsequence
    sequence col_two_s;
        col_blocked && $past(col_blocked) ##1 !col_blocked;
    endsequence
    apb_wait_a: assert property (pce && psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_data_a: assert property (pready && pslverr |-> prdata == 32'h00000000)
        else $error("error response with data");
    rsvd_zero_a: assert property (pready && !pwrite && !pslverr
        && paddr == dmtc_pkg::MTC_OFFSET
        |-> (prdata & ~dmtc_pkg::MTC_WMASK) == 32'h00000000)
        else $error("reserved bits read nonzero");
    hold_write_a: assert property (wr_hit |=> row_strobe_hold_mode == $past(pwdata[31]))
        else $error("row hold mode not updated");
    manual_keep_a: assert property (manual_reset && !wr_hit |=> $stable(row_strobe_hold_mode))
        else $error("manual reset changed register");
    col_delay_a: assert property (!$past(manual_reset) && bank_active && !col_negate
        && !manual_reset && !sdram_sel && shadow_q[17:16] == 2'h0 && !col_blocked
        ##1 quiet_s [*2] |-> col_two_s)
        else $error("row to column delay wrong");
    refresh_zero_a: assert property (refresh_end && shadow_q[29:27] == 3'h0
        && !activate_blocked && !row_negate && !precharge_issued && !write_end
        |=> !activate_blocked)
        else $error("zero refresh precharge blocked");
    cfg_error_a: assert property (sdram_sel && shadow_q[17:16] == 2'h0
        && $stable(shadow_q) && $stable(sdram_sel) |-> config_error)
        else $error("barred delay code not flagged");
endmodule // dmtc_top_assertions
bind dmtc_top dmtc_top_assertions chk_u (.*);
`default_nettype wire

// ---- dv/dmtc_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dmtc_mem_model (
    input wire logic pclk,
    input wire logic armed,
    input wire logic [5:0] req,
    output logic [5:0] ev
);
    // Memory stays silent until setup is done
    always_ff @(posedge pclk) ev <= armed ? req : 6'h00;
endmodule // dmtc_mem_model
`default_nettype wire

// ---- dv/dmtc_top_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module dmtc_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic manual_reset = 1'b0;
    logic sdram_sel = 1'b0;
    logic armed = 1'b0;
    logic [dmtc_pkg::ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, hold_mode, setup_cmd;
    logic [3:0] blk;
    logic [5:0] req = 6'h00;
    logic [5:0] ev;
    int n_errors = 0;
    int check_count = 0;
    dmtc_top dut_u (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .manual_reset(manual_reset), .sdram_sel(sdram_sel),
        .refresh_end(ev[0]), .row_negate(ev[1]), .precharge_issued(ev[2]),
        .bank_active(ev[3]), .col_negate(ev[4]), .write_end(ev[5]),
        .row_strobe_hold_mode(hold_mode), .sdram_setup_command_select(setup_cmd),
        .activate_blocked(blk[0]), .col_blocked(blk[1]), .precharge_blocked(blk[2]),
        .config_error(blk[3]));
    dmtc_mem_model mem_u (.pclk(pclk), .armed(armed), .req(req), .ev(ev));
    initial forever #50 pclk = ~pclk;
    task automatic test_done;
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            test_done;
        end
    endtask
    task automatic run(input logic [31:0] cfg, input logic sd, input int e, input int o,
                       input int exp);
        int n;
        n = 0;
        @(posedge pclk);
        sdram_sel <= sd;
        apb(1'b1, dmtc_pkg::MTC_OFFSET, cfg);
        @(posedge pclk);
        req <= 6'(1 << e);
        @(posedge pclk);
        req <= 6'h00;
        @(posedge pclk);
        repeat (40) begin
            @(negedge pclk);
            if (blk[o] === 1'b1) n++;
        end
        cmp("blocked cycles", 32'(exp), 32'(n));
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, dmtc_pkg::MTC_OFFSET, 32'h00000000);
        cmp("reset value", 32'h00000000, rd);
        apb(1'b1, dmtc_pkg::MTC_OFFSET, 32'hFFFFFFFF);
        apb(1'b0, dmtc_pkg::MTC_OFFSET, 32'h00000000);
        cmp("masked value", dmtc_pkg::MTC_WMASK, rd);
        cmp("mode outputs", 32'h00000003, {30'h0, hold_mode, setup_cmd});
        @(posedge pclk);
        manual_reset <= 1'b1;
        @(posedge pclk);
        manual_reset <= 1'b0;
        apb(1'b0, dmtc_pkg::MTC_OFFSET, 32'h00000000);
        cmp("kept value", dmtc_pkg::MTC_WMASK, rd);
        apb(1'b0, 12'h008, 32'h00000000);
        cmp("unmapped error", 32'h00000001, {31'h0, err});
        @(posedge pclk);
        armed <= 1'b1;
        run(32'h38BB0000, 1'b0, 0, 0, 21);
        run(32'h38BB0000, 1'b0, 1, 0, 7);
        run(32'h38BB0000, 1'b0, 3, 1, 5);
        run(32'h38BB0000, 1'b0, 4, 1, 2);
        run(32'h38BB0000, 1'b0, 2, 0, 0);
        run(32'h00000000, 1'b0, 3, 1, 2);
        run(32'h00000000, 1'b0, 0, 0, 0);
        run(32'h00398000, 1'b1, 2, 0, 8);
        run(32'h00398000, 1'b1, 3, 1, 2);
        run(32'h00398000, 1'b1, 5, 0, 13);
        run(32'h00398000, 1'b1, 4, 1, 0);
        run(32'h8012E000, 1'b1, 5, 2, 5);
        run(32'h8012E000, 1'b1, 6, 3, 40);
        run(32'h80190000, 1'b1, 6, 3, 40);
        apb(1'b0, dmtc_pkg::STATUS_OFFSET, 32'h00000000);
        cmp("status word", 32'h00000008, rd);
        run(32'h00000000, 1'b1, 6, 3, 40);
        run(32'h00010000, 1'b1, 6, 3, 0);
        @(posedge pclk);
        pce <= 1'b0;
        req <= 6'h08;
        @(posedge pclk);
        req <= 6'h00;
        @(posedge pclk);
        @(negedge pclk);
        cmp("frozen blocked", 32'h00000000, {31'h0, blk[1]});
        @(posedge pclk);
        pce <= 1'b1;
        test_done;
    end
endmodule // dmtc_top_bench
`default_nettype wire
